/* File: inc/smals_defs.svh */
// Constants for the max address lock security command interpreter
`ifndef SMALS_DEFS_SVH
`define SMALS_DEFS_SVH
`define SMALS_CMD_SET_MAX      8'hF9
`define SMALS_CMD_READ_NATIVE  8'hF8
`define SMALS_FEAT_SET_PW      8'h01
`define SMALS_FEAT_LOCK        8'h02
`define SMALS_FEAT_UNLOCK      8'h03
`define SMALS_FEAT_FREEZE      8'h04
`define SMALS_TRIES_INIT       3'h5
`define SMALS_PW_FIRST_WORD    8'h01
`define SMALS_PW_LAST_WORD     8'h10
`define SMALS_SECTOR_LAST_WORD 8'hFF
`endif

/* File: inc/smals_pkg.sv */
// Types for the max address lock security command interpreter
package smals_pkg;
   typedef enum logic [1:0] {SMALS_UNLOCKED, SMALS_LOCKED, SMALS_FROZEN} smals_lock_t;
   typedef enum logic [1:0] {SMALS_IDLE, SMALS_RX_PW, SMALS_RX_UNLOCK} smals_phase_t;
   typedef struct packed {
      smals_lock_t    lock;
      smals_phase_t   phase;
      logic [2:0]     tries;
      logic [255:0]   pw;
      logic           pw_set;
      logic           after_native;
      logic [7:0]     word_idx;
      logic           mismatch;
      logic [255:0]   rx_pw;
      logic           done;
      logic           abort_flag;
      logic           error_flag;
      logic           busy_flag;
      logic           device_fault_flag;
      logic           data_req;
      logic           do_set_max;
      logic           do_read_native;
   } smals_state_t;
endpackage

/* File: verilog/smals_core.sv */
// Max address lock security command interpreter
//
// Notes on behaviour
// - F9h with feature 01h means set password
// - After read native: password/unlock/freeze become set max
// - After read native: lock becomes read native
// - Password kept till power cycle; set only unlocked
// - Lock feature 02h enters locked on completion
// - Locked rejects all except unlock, freeze, lock right after read native
// - Locked until power, unlock or freeze
// - Unlock 03h compares received sector to password
// - Mismatch aborts and decrements attempt counter
// - Attempt counter starts at five
// - Counter zero rejects unlock until reset
// - Match enters unlocked, all accepted
// - Freeze feature 04h enters frozen
// - Frozen rejects every later set max command except lock right after read native
// - Plain F9h dispatched by feature value
// - Set max while locked or frozen aborts
`include "smals_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Interface
// ----------------------------------------
module smals_core (
   // Clock, reset, enable
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         clk_en,
   // Command issue from task file logic (same clock)
   input  wire logic         cmd_valid,
   input  wire logic [7:0]   cmd_code,
   input  wire logic [7:0]   cmd_feature,
   // Data sector words from host
   input  wire logic         data_valid,
   input  wire logic [15:0]  data_word,
   // Completion and status
   output logic              cmd_done,
   output logic              abort_flag,
   output logic              error_flag,
   output logic              busy_flag,
   output logic              device_fault_flag,
   output logic              data_req,
   output logic              do_set_max,
   output logic              do_read_native,
   output logic [1:0]        lock_state,
   output logic [2:0]        tries_left
);
   // ----------------------------------------
   // State and decode helpers
   // ----------------------------------------
   smals_pkg::smals_state_t s_r;
   smals_pkg::smals_state_t s_nxt;
   logic                    last_word;
   logic                    in_pw;
   logic                    is_native;
   logic                    is_set_max;
   logic                    now_unlocked;
   logic                    now_frozen;
   logic                    tries_gone;
   logic                    word_ok;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   always_comb begin
      last_word = (s_r.word_idx == `SMALS_SECTOR_LAST_WORD);
      in_pw = (s_r.word_idx >= `SMALS_PW_FIRST_WORD) && (s_r.word_idx <= `SMALS_PW_LAST_WORD);
      is_native = (cmd_code == `SMALS_CMD_READ_NATIVE);
      is_set_max = (cmd_code == `SMALS_CMD_SET_MAX);
      now_unlocked = (s_r.lock == smals_pkg::SMALS_UNLOCKED);
      now_frozen = (s_r.lock == smals_pkg::SMALS_FROZEN);
      tries_gone = (s_r.tries == 3'h0);
      // Word 1 sits in the top bits of the stored password
      // No stored password means no word can ever match
      word_ok = s_r.pw_set
                && (data_word == s_r.pw[16*(`SMALS_PW_LAST_WORD - s_r.word_idx) +: 16]);
   end

   // ----------------------------------------
   // Command decode and sector intake
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      // Pulses last one cycle only
      s_nxt.done = 1'b0;
      s_nxt.do_set_max = 1'b0;
      s_nxt.do_read_native = 1'b0;
      case (s_r.phase)
         smals_pkg::SMALS_IDLE: begin
            if (cmd_valid) begin
               // Flags of the previous command stand until here
               s_nxt.busy_flag = 1'b1;
               s_nxt.abort_flag = 1'b0;
               s_nxt.error_flag = 1'b0;
               s_nxt.device_fault_flag = 1'b0;
               // Any taken command but read native, or lock just after it, closes the read native window
               s_nxt.after_native = is_native;
               s_nxt.word_idx = 8'h00;
               s_nxt.mismatch = 1'b0;
               if (is_native) begin
                  s_nxt.do_read_native = 1'b1;
                  s_nxt.busy_flag = 1'b0;
                  s_nxt.done = 1'b1;
               end else if (!is_set_max) begin
                  // Other commands pass by; the native flag and the status flags are cleared
                  s_nxt.busy_flag = 1'b0;
               end else if (s_r.after_native) begin
                  // Lock here is only a repeated read
                  if (cmd_feature == `SMALS_FEAT_LOCK) begin
                     s_nxt.do_read_native = 1'b1;
                     s_nxt.after_native = 1'b1;
                  end else if (!now_unlocked) begin
                     s_nxt.abort_flag = 1'b1;
                     s_nxt.error_flag = 1'b1;
                  end else begin
                     s_nxt.do_set_max = 1'b1;
                  end
                  s_nxt.busy_flag = 1'b0;
                  s_nxt.done = 1'b1;
               end else begin
                  s_nxt.busy_flag = 1'b0;
                  s_nxt.done = 1'b1;
                  // Data commands raise busy and wait for a sector
                  if (cmd_feature == `SMALS_FEAT_SET_PW && now_unlocked) begin
                     s_nxt.phase = smals_pkg::SMALS_RX_PW;
                     s_nxt.busy_flag = 1'b1;
                     s_nxt.data_req = 1'b1;
                     s_nxt.done = 1'b0;
                  end else if (cmd_feature == `SMALS_FEAT_LOCK && now_unlocked) begin
                     s_nxt.lock = smals_pkg::SMALS_LOCKED;
                  end else if (cmd_feature == `SMALS_FEAT_UNLOCK && !now_frozen && !tries_gone) begin
                     s_nxt.phase = smals_pkg::SMALS_RX_UNLOCK;
                     s_nxt.busy_flag = 1'b1;
                     s_nxt.data_req = 1'b1;
                     s_nxt.done = 1'b0;
                  end else if (cmd_feature == `SMALS_FEAT_FREEZE && !now_frozen) begin
                     s_nxt.lock = smals_pkg::SMALS_FROZEN;
                  end else begin
                     // Unknown feature, locked, frozen, or no tries left
                     s_nxt.abort_flag = 1'b1;
                     s_nxt.error_flag = 1'b1;
                  end
               end
            end
         end

         default: begin
            // Commands arriving mid-sector are ignored
            if (data_valid) begin
               s_nxt.word_idx = s_r.word_idx + 8'h01;
               // Words past the password are counted, not kept
               if (in_pw) begin
                  s_nxt.rx_pw = {s_r.rx_pw[239:0], data_word};
                  // Keep comparing; the verdict waits for the last word
                  if (s_r.phase == smals_pkg::SMALS_RX_UNLOCK) begin
                     if (!word_ok) begin
                        s_nxt.mismatch = 1'b1;
                     end
                  end
               end
               // The 256th word closes the sector
               if (last_word) begin
                  s_nxt.phase = smals_pkg::SMALS_IDLE;
                  s_nxt.data_req = 1'b0;
                  s_nxt.busy_flag = 1'b0;
                  s_nxt.done = 1'b1;
                  if (s_r.phase == smals_pkg::SMALS_RX_PW) begin
                     s_nxt.pw = s_r.rx_pw;
                     s_nxt.pw_set = 1'b1;
                  end else if (s_r.mismatch) begin
                     // Cannot wrap: unlock is refused at zero
                     s_nxt.tries = s_r.tries - 3'h1;
                     s_nxt.abort_flag = 1'b1;
                     s_nxt.error_flag = 1'b1;
                  end else begin
                     s_nxt.lock = smals_pkg::SMALS_UNLOCKED;
                  end
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         // Password and attempt count survive all but reset
         s_r <= '0;
         s_r.lock <= smals_pkg::SMALS_UNLOCKED;
         s_r.phase <= smals_pkg::SMALS_IDLE;
         s_r.tries <= `SMALS_TRIES_INIT;
      end else if (clk_en) begin
         // Enable low holds every field, sector count too
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Every output is a plain copy of a state field
   always_comb begin
      cmd_done = s_r.done;
      abort_flag = s_r.abort_flag;
      error_flag = s_r.error_flag;
      busy_flag = s_r.busy_flag;
      device_fault_flag = s_r.device_fault_flag;
      data_req = s_r.data_req;
      do_set_max = s_r.do_set_max;
      do_read_native = s_r.do_read_native;
      lock_state = s_r.lock;
      tries_left = s_r.tries;
   end
endmodule
`default_nettype wire

/* File: verification/smals_core_monitor.sv */
// Port checker for the max address lock security interpreter
`timescale 1ns/1ps
`default_nettype none
module smals_core_monitor (
   // Clock, reset and command side
   input wire logic        mclk, rst, clk_en, cmd_valid, data_valid,
   input wire logic [7:0]  cmd_code, cmd_feature,
   input wire logic [15:0] data_word,
   // Completion and state
   input wire logic        cmd_done, abort_flag, error_flag, busy_flag, device_fault_flag,
   input wire logic        data_req, do_set_max, do_read_native,
   input wire logic [1:0]  lock_state,
   input wire logic [2:0]  tries_left
);
   // ----------------------------------------
   // Command tracking
   // ----------------------------------------
   logic      nat_r;
   wire logic take = cmd_valid && clk_en && !busy_flag;
   wire logic f9   = take && cmd_code == 8'hF9 && !nat_r;
   wire logic n9   = take && cmd_code == 8'hF9 && nat_r;
   always_ff @(posedge mclk) begin
      if (rst) nat_r <= 1'b0;
      else if (take) nat_r <= (cmd_code == 8'hF8);
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   AST_LOCK: assert property (f9 && cmd_feature == 8'h02 && lock_state == 2'h0
      |=> cmd_done && lock_state == 2'h1 && !abort_flag) else $error("lock not entered");
   AST_LOCKED_REJ: assert property (f9 && lock_state == 2'h1
      && cmd_feature inside {8'h01, 8'h02} |=> cmd_done && abort_flag && lock_state == 2'h1)
      else $error("locked state accepted a command");
   AST_FROZEN_REJ: assert property (take && cmd_code == 8'hF9 && lock_state == 2'h2
      && !(nat_r && cmd_feature == 8'h02) |=> ##[0:260] cmd_done && abort_flag)
      else $error("frozen state accepted a command");
   AST_FROZEN_STAY: assert property (lock_state == 2'h2 |=> lock_state == 2'h2)
      else $error("frozen state left");
   AST_FREEZE: assert property (f9 && cmd_feature == 8'h04 && lock_state != 2'h2
      |=> cmd_done && lock_state == 2'h2) else $error("freeze not entered");
   AST_ABORT_FLAGS: assert property (abort_flag
      |-> error_flag && !busy_flag && !device_fault_flag) else $error("bad abort flags");
   AST_NATIVE_LOCK: assert property (n9 && cmd_feature == 8'h02 && lock_state == 2'h0
      |=> do_read_native && lock_state == 2'h0) else $error("lock after native mishandled");
   AST_NATIVE_SETMAX: assert property (n9 && cmd_feature != 8'h02 && lock_state == 2'h0
      |=> do_set_max && !data_req) else $error("plain set max not run");
   AST_PW_SECTOR: assert property (f9 && lock_state == 2'h0
      && (cmd_feature == 8'h01 || (cmd_feature == 8'h03 && tries_left != 3'h0))
      |=> busy_flag && data_req) else $error("sector not requested");
   AST_TRIES: assert property (tries_left != $past(tries_left)
      |-> tries_left == $past(tries_left) - 3'h1 && abort_flag) else $error("bad attempt count");
   AST_NO_TRIES: assert property (f9 && cmd_feature == 8'h03 && tries_left == 3'h0
      |=> ##[0:260] cmd_done && abort_flag) else $error("unlock accepted with no attempts");
   cover property (f9 && cmd_feature == 8'h03 && lock_state == 2'h1);
   cover property (lock_state == 2'h2);
   cover property (tries_left == 3'h0);
endmodule
bind smals_core smals_core_monitor u_mon (.*);
`default_nettype wire

/* File: verification/smals_host_model.sv */
// Host model that supplies password sector words on request
`timescale 1ns/1ps
`default_nettype none
module smals_host_model (
   input  wire logic         mclk, rst, data_req,
   input  wire logic [255:0] pw,
   output logic              data_valid = 1'b0,
   output logic [15:0]       data_word  = 16'h0000
);
   logic [8:0] idx = 9'h000;
   // Idle and reserved words toggle so stale data never looks meaningful
   always @(posedge mclk) begin
      if (rst || !data_req) begin
         idx <= 9'h000;
         data_valid <= 1'b0;
         data_word <= ~data_word;
      end else if (idx < 9'h100) begin
         data_valid <= 1'b1;
         data_word <= (idx >= 9'h001 && idx <= 9'h010) ? pw[16*(16-idx) +: 16] : ~data_word;
         idx <= idx + 9'h001;
      end else data_valid <= 1'b0;
   end
endmodule
`default_nettype wire

/* File: verification/smals_core_tb.sv */
// Testbench for the max address lock security interpreter
`timescale 1ns/1ps
`default_nettype none
module smals_core_tb;
   logic mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, data_valid, cmd_done, abort_flag, error_flag;
   logic busy_flag, device_fault_flag, data_req, do_set_max, do_read_native, g_ab, g_sm, g_rn;
   logic [7:0] cmd_code = 8'h00, cmd_feature = 8'h00;
   logic clk_en = 1'b1;
   logic [15:0] data_word;
   logic [1:0] lock_state;
   logic [2:0] tries_left;
   logic [255:0] pw = 256'h0, good = {16{16'hA5C3}} ^ 256'h1234_5678;
   int errors = 0, compares = 0, cyc = 0;
   smals_core uut (.*);
   smals_host_model host (.*);
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin errors++; wrap_up(); end
   end
   task wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(string n, logic [7:0] e, logic [7:0] g);
      compares++;
      if (e !== g) begin errors++; $display("unexpected %s expected %h seen %h", n, e, g); end
   endtask
   // One command, then wait for its one-cycle answer
   task cmd(logic [7:0] c, logic [7:0] f);
      logic got;
      got = 1'b0;
      @(posedge mclk);
      cmd_code <= c; cmd_feature <= f; cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      {g_ab, g_sm, g_rn} = 3'h0;
      // The answer of a plain command stands right after the taking edge
      repeat (300) begin
         #1;
         if (cmd_done | do_set_max | do_read_native) begin
            {g_ab, g_sm, g_rn} = {abort_flag, do_set_max, do_read_native};
            got = 1'b1;
            break;
         end
         @(posedge mclk);
      end
      chk("answer", 1, got);
   endtask
   task t_hold();
      @(posedge mclk);
      clk_en <= 1'b0; cmd_code <= 8'hF9; cmd_feature <= 8'h04; cmd_valid <= 1'b1;
      repeat (3) @(posedge mclk);
      clk_en <= 1'b1; cmd_valid <= 1'b0;
      @(posedge mclk); #1;
      chk("lock", 0, lock_state); chk("done", 0, cmd_done);
   endtask
   task t_power(); chk("lock", 0, lock_state); chk("tries", 5, tries_left); endtask
   task t_native();
      cmd(8'hF8, 0); cmd(8'hF9, 8'h02); chk("rn", 1, g_rn); chk("lock", 0, lock_state);
      cmd(8'hF8, 0); cmd(8'hF9, 8'h04); chk("sm", 1, g_sm); chk("lock", 0, lock_state);
   endtask
   task t_setpw(); pw = good; cmd(8'hF9, 8'h01); chk("ab", 0, g_ab); endtask
   task t_lock();
      cmd(8'hF9, 8'h02); chk("lock", 1, lock_state);
      cmd(8'hF9, 8'h01); chk("ab", 1, g_ab);
      cmd(8'hF8, 0); cmd(8'hF9, 8'h04); chk("ab", 1, g_ab); chk("lock", 1, lock_state);
   endtask
   task t_unlock();
      pw = ~good; cmd(8'hF9, 8'h03); chk("ab", 1, g_ab); chk("tries", 4, tries_left);
      pw = good; cmd(8'hF9, 8'h03); chk("ab", 0, g_ab); chk("lock", 0, lock_state);
   endtask
   task t_zero();
      cmd(8'hF9, 8'h02); chk("ab", 0, g_ab);
      pw = ~good;
      repeat (4) cmd(8'hF9, 8'h03);
      chk("tries", 0, tries_left);
      pw = good; cmd(8'hF9, 8'h03); chk("ab", 1, g_ab); chk("lock", 1, lock_state);
   endtask
   task t_freeze();
      cmd(8'hF9, 8'h04); chk("lock", 2, lock_state);
      cmd(8'hF9, 8'h03); chk("ab", 1, g_ab);
      cmd(8'hF9, 8'h02); chk("ab", 1, g_ab); chk("lock", 2, lock_state);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk); #1;
      t_power(); t_native(); t_hold(); t_setpw(); t_lock(); t_unlock(); t_zero(); t_freeze();
      wrap_up();
   end
endmodule
`default_nettype wire
